// ===== memory_map_decoder_remap.sv
// First-level address decoder with remap and coupled SRAM partitioning
// Summary of operation
// - Top four address bits select sixteen banks
// - Banks one to six drive external selects
// - Bank seven drives the DRAM chip select
// - Bank zero decodes internal area in 1 MB regions
// - Bank fifteen goes to peripheral bridge
// - Unmapped addresses return an abort response
// - SRAM is 64 KB, four 16 KB blocks
// - Bus-only SRAM at 0x300000, also zero after remap
// - ROM always answers at 0x400000
// - Boot select aliases ROM at zero before remap
// - Three legal SRAM partition splits only
// - Instr, data and bus-only parts at 0x100000, 0x200000, 0x300000
// - Wait bit adds one wait state to in-range coupled accesses
// - Bus-only part at zero for processor masters
// - SRAM serves coupled and bus ports
// - Data part stays reachable by all masters
`include "mem_map_defs.svh"

module memory_map_decoder_remap
    import mem_map_pkg::*;
(
    input  wire logic        clk_sys,               // Bus clock
    input  wire logic        resetn,                // Async reset, low
    input  wire logic        bus_valid,             // Bus access request
    input  wire logic [31:0] bus_addr,              // Bus access address
    input  wire logic        bus_master_cpu,        // Master is processor
    input  wire logic        coupled_valid,         // Coupled port access
    input  wire logic        coupled_is_instr,      // Coupled instr side
    input  wire logic [15:0] coupled_addr,          // Coupled byte offset
    input  wire logic        remap_cmd,             // One-shot remap request
    input  wire logic        boot_memory_select,    // Boot select pin
    input  wire logic [1:0]  coupled_map_config,    // Partition select
    input  wire logic        coupled_mem_wait_state,// Extra wait enable
    output logic [5:0]       ext_select_n,          // Ext selects, low
    output logic             dram_chip_select_n,    // DRAM select, low
    output logic             periph_select,         // Peripheral bridge
    output logic             sram_bus_select,       // SRAM bus port
    output logic [15:0]      sram_bus_offset,       // SRAM array offset
    output logic             rom_select,            // Internal ROM
    output logic             alt_boot_select,       // Alternate boot
    output logic             bus_abort,             // Error response
    output logic             bus_ready,             // Bus access done
    output logic             coupled_sram_select,   // Coupled SRAM hit
    output logic             coupled_abort,         // Coupled out of range
    output logic             coupled_ready,         // Coupled access done
    output logic             remapped,              // Remap state
    output logic [1:0]       split_active           // Partition in force
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic boot_meta_q;   // First stage, read only by second
    logic boot_sync_q;   // Synchronised boot select
    logic boot_sync_d;
    logic boot_strap_q;  // Boot select caught after reset
    logic boot_strap_d;
    logic [1:0] strap_cnt_q;  // Edges since release, saturates
    logic [1:0] strap_cnt_d;

    // Next values for the strap capture
    always_comb begin
        boot_sync_d  = boot_meta_q;
        strap_cnt_d  = strap_cnt_q + {1'h0, ~&strap_cnt_q};
        // Load for three edges, so both stages hold the pin first
        boot_strap_d = &strap_cnt_q ? boot_strap_q : boot_sync_q;
    end

    // Registers of the strap capture
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            boot_meta_q  <= 1'h0;
            boot_sync_q  <= 1'h0;
            boot_strap_q <= 1'h0;
            strap_cnt_q  <= 2'h0;
        end else begin
            boot_meta_q  <= boot_memory_select;
            boot_sync_q  <= boot_sync_d;
            boot_strap_q <= boot_strap_d;
            strap_cnt_q  <= strap_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Remap and configuration state
    // ------------------------------------------------------------------
    logic       remap_q;   // Set by remap command
    logic       remap_d;
    logic [1:0] split_q;   // Legal partition selection
    logic [1:0] split_d;
    logic       wait_q;    // Coupled wait-state enable
    logic       wait_d;

    // Next values for remap and configuration
    always_comb begin
        remap_d = remap_q | remap_cmd;
        split_d = split_q;
        // Illegal codes are ignored, keeping the last legal split
        unique case (coupled_map_config)
            `SPLIT_BUS_ONLY,
            `SPLIT_DATA_ALL,
            `SPLIT_HALF_HALF: split_d = coupled_map_config;
            default:          split_d = split_q;
        endcase
        wait_d = coupled_mem_wait_state;
    end

    // Registers of remap and configuration
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            remap_q <= `RESET_REMAP;
            split_q <= `RESET_SPLIT;
            wait_q  <= `RESET_WAIT;
        end else begin
            remap_q <= remap_d;
            split_q <= split_d;
            wait_q  <= wait_d;
        end
    end

    // ------------------------------------------------------------------
    // Partition sizes
    // ------------------------------------------------------------------
    logic [31:0] instr_size;   // Instruction-coupled bytes
    logic [31:0] data_size;    // Data-coupled bytes
    logic [31:0] busonly_size; // Bus-only bytes

    // Sizes per split; all parts total 64 KB of four blocks
    always_comb begin
        instr_size   = 32'h0000_0000;
        data_size    = 32'h0000_0000;
        busonly_size = 32'h0000_0000;
        unique case (split_q)
            `SPLIT_DATA_ALL: begin
                data_size = `SRAM_BYTES;
            end
            `SPLIT_HALF_HALF: begin
                instr_size = `SRAM_HALF_BYTES;
                data_size  = `SRAM_HALF_BYTES;
            end
            default: begin
                busonly_size = `SRAM_BYTES;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [3:0]  bank;       // Bank number
    logic [7:0]  region;     // 1 MB region in bank 0
    logic [31:0] low;        // Offset in region
    target_t     tgt;        // Decoded destination
    logic [2:0]  ext_idx;    // External select index
    logic [15:0] sram_off;   // Offset into SRAM arrays

    assign bank   = bus_addr[`BANK_MSB:`BANK_LSB];
    assign region = bus_addr[`REGION_MSB:`REGION_LSB];
    assign low    = {12'h000, bus_addr[19:0]};
    assign ext_idx = 3'(bank - `BANK_EXT_FIRST);

    // Destination and array offset for a bus access
    always_comb begin
        tgt      = TGT_NONE;
        sram_off = 16'h0000;
        if (bus_valid) begin
            tgt = TGT_ABORT;
            if (bank >= `BANK_EXT_FIRST && bank <= `BANK_EXT_LAST) begin
                tgt = TGT_EXT;
            end else if (bank == `BANK_DRAM) begin
                tgt = TGT_DRAM;
            end else if (bank == `BANK_PERIPH) begin
                tgt = TGT_PERIPH;
            end else if (bank == `BANK_INTERNAL) begin
                unique case (region)
                    `REGION_ZERO: begin
                        if (remap_q) begin
                            // Only processor masters see SRAM at zero
                            if (bus_master_cpu &&
                                low < busonly_size) begin
                                tgt      = TGT_SRAM;
                                sram_off = low[15:0];
                            end
                        end else if (boot_strap_q) begin
                            if (low < `ROM_BYTES) tgt = TGT_ROM;
                        end else begin
                            tgt = TGT_ALT_BOOT;
                        end
                    end
                    `REGION_INSTR: begin
                        if (low < instr_size) begin
                            tgt      = TGT_SRAM;
                            sram_off = low[15:0];
                        end
                    end
                    `REGION_DATA: begin
                        if (low < data_size) begin
                            tgt      = TGT_SRAM;
                            sram_off = 16'(low + instr_size);
                        end
                    end
                    `REGION_BUSONLY: begin
                        if (low < busonly_size) begin
                            tgt      = TGT_SRAM;
                            sram_off = low[15:0];
                        end
                    end
                    `REGION_ROM: begin
                        if (low < `ROM_BYTES) tgt = TGT_ROM;
                    end
                    default: tgt = TGT_ABORT;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus-side select registers
    // ------------------------------------------------------------------
    logic [5:0]  ext_n_d;
    logic [5:0]  ext_n_q;
    logic        dram_n_d;
    logic        dram_n_q;
    logic [6:0]  bus_sel_d;  // periph,sram,rom,alt,abort,ready,spare
    logic [6:0]  bus_sel_q;
    logic [15:0] off_q;

    // Registered selects, one cycle after the request
    always_comb begin
        ext_n_d  = 6'h3F;
        if (tgt == TGT_EXT) ext_n_d[ext_idx] = 1'h0;
        dram_n_d = (tgt != TGT_DRAM);
        bus_sel_d = {tgt == TGT_PERIPH, tgt == TGT_SRAM,
                     tgt == TGT_ROM, tgt == TGT_ALT_BOOT,
                     tgt == TGT_ABORT, tgt != TGT_NONE, 1'h0};
    end

    // Select registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ext_n_q   <= 6'h3F;
            dram_n_q  <= 1'h1;
            bus_sel_q <= 7'h00;
            off_q     <= 16'h0000;
        end else begin
            ext_n_q   <= ext_n_d;
            dram_n_q  <= dram_n_d;
            bus_sel_q <= bus_sel_d;
            off_q     <= sram_off;
        end
    end

    // ------------------------------------------------------------------
    // Coupled port with optional wait state
    // ------------------------------------------------------------------
    wait_state_t cst_q;      // Wait sequencer state
    wait_state_t cst_d;
    logic        c_hit;      // Coupled access in range
    logic        c_sel_d;
    logic        c_sel_q;
    logic        c_abt_d;
    logic        c_abt_q;
    logic        c_rdy_d;
    logic        c_rdy_q;

    // Range check against the coupled part in use
    assign c_hit = coupled_is_instr ?
                   ({16'h0000, coupled_addr} < instr_size) :
                   ({16'h0000, coupled_addr} < data_size);

    // Coupled sequencer, holds in-range accesses one extra cycle when enabled
    always_comb begin
        cst_d   = cst_q;
        c_sel_d = 1'h0;
        c_abt_d = 1'h0;
        c_rdy_d = 1'h0;
        unique case (cst_q)
            ST_IDLE: begin
                if (coupled_valid) begin
                    c_sel_d = c_hit;
                    if (wait_q && c_hit) begin
                        cst_d = ST_WAIT;
                    end else begin
                        c_abt_d = !c_hit;
                        c_rdy_d = 1'h1;
                    end
                end
            end
            ST_WAIT: begin
                c_sel_d = 1'h1;
                c_rdy_d = 1'h1;
                cst_d   = ST_IDLE;
            end
        endcase
    end

    // Coupled registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cst_q   <= ST_IDLE;
            c_sel_q <= 1'h0;
            c_abt_q <= 1'h0;
            c_rdy_q <= 1'h0;
        end else begin
            cst_q   <= cst_d;
            c_sel_q <= c_sel_d;
            c_abt_q <= c_abt_d;
            c_rdy_q <= c_rdy_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign ext_select_n        = ext_n_q;
    assign dram_chip_select_n  = dram_n_q;
    assign periph_select       = bus_sel_q[6];
    assign sram_bus_select     = bus_sel_q[5];
    assign rom_select          = bus_sel_q[4];
    assign alt_boot_select     = bus_sel_q[3];
    assign bus_abort           = bus_sel_q[2];
    assign bus_ready           = bus_sel_q[1];
    assign sram_bus_offset     = off_q;
    assign coupled_sram_select = c_sel_q;
    assign coupled_abort       = c_abt_q;
    assign coupled_ready       = c_rdy_q;
    assign remapped            = remap_q;
    assign split_active        = split_q;

endmodule : memory_map_decoder_remap

// ===== mem_map_defs.svh
// Address map constants for the first-level memory map decoder
`ifndef MEM_MAP_DEFS_SVH
`define MEM_MAP_DEFS_SVH

// ----------------------------------------------------------------------
// Bank decode
// ----------------------------------------------------------------------
`define BANK_MSB            31
`define BANK_LSB            28
`define BANK_INTERNAL       4'h0
`define BANK_EXT_FIRST      4'h1
`define BANK_EXT_LAST       4'h6
`define BANK_DRAM           4'h7
`define BANK_PERIPH         4'hF

// ----------------------------------------------------------------------
// Internal memory area, second-level decode (1 MB regions in bank 0)
// ----------------------------------------------------------------------
`define REGION_MSB          27
`define REGION_LSB          20
`define REGION_ZERO         8'h00
`define REGION_INSTR        8'h01
`define REGION_DATA         8'h02
`define REGION_BUSONLY      8'h03
`define REGION_ROM          8'h04

// ----------------------------------------------------------------------
// Memory sizes in bytes
// ----------------------------------------------------------------------
`define SRAM_BYTES          32'h0001_0000
`define SRAM_HALF_BYTES     32'h0000_8000
`define SRAM_BLOCK_BYTES    32'h0000_4000
`define ROM_BYTES           32'h0001_0000

// ----------------------------------------------------------------------
// Partition encodings
// ----------------------------------------------------------------------
`define SPLIT_BUS_ONLY      2'h0
`define SPLIT_DATA_ALL      2'h1
`define SPLIT_HALF_HALF     2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RESET_SPLIT         2'h0
`define RESET_WAIT          1'h0
`define RESET_REMAP         1'h0

`endif

// ===== mem_map_pkg.sv
// Types shared by the memory map decoder
package mem_map_pkg;

    // Destination of a decoded access
    typedef enum logic [3:0] {
        TGT_NONE,
        TGT_EXT,
        TGT_DRAM,
        TGT_SRAM,
        TGT_ROM,
        TGT_PERIPH,
        TGT_ALT_BOOT,
        TGT_ABORT
    } target_t;

    // Wait-state sequencer state
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_WAIT
    } wait_state_t;

endpackage : mem_map_pkg

// ===== memory_map_decoder_remap_assertions.sv
// Port level assertions for the memory map decoder
module memory_map_decoder_remap_checker (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        bus_valid,
    input wire logic [31:0] bus_addr,
    input wire logic        coupled_valid,
    input wire logic        coupled_mem_wait_state,
    input wire logic [1:0]  coupled_map_config,
    input wire logic        remap_cmd,
    input wire logic [5:0]  ext_select_n,
    input wire logic        dram_chip_select_n,
    input wire logic        periph_select,
    input wire logic        sram_bus_select,
    input wire logic        rom_select,
    input wire logic        alt_boot_select,
    input wire logic        bus_abort,
    input wire logic        bus_ready,
    input wire logic        coupled_sram_select,
    input wire logic        coupled_ready,
    input wire logic        remapped,
    input wire logic [1:0]  split_active
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Bank of the request being answered (answer lags by one edge)
    // ------------------------------------------------------------
    logic [3:0] bank_d;
    logic [3:0] bank_q;
    always_comb bank_d = bus_addr[31:28];
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bank_q <= 4'h0;
        end else begin
            bank_q <= bank_d;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    AST_BUS_ANSWER: assert property (bus_valid |=> bus_ready)
        else $error("bus request not answered");
    AST_ONE_TARGET: assert property (bus_ready |-> $onehot({
        ~ext_select_n, !dram_chip_select_n, periph_select, sram_bus_select,
        rom_select, alt_boot_select, bus_abort})) else $error("not one target");
    AST_IDLE_QUIET: assert property (!bus_ready |-> ext_select_n == 6'h3F
        && dram_chip_select_n && !periph_select && !bus_abort)
        else $error("select without request");
    AST_EXT_BANK: assert property (bus_ready && bank_q inside {[1:6]}
        |-> ext_select_n == ~(6'h01 << (bank_q - 4'h1)))
        else $error("wrong external select");
    AST_DRAM_BANK: assert property (bus_ready |->
        !dram_chip_select_n == (bank_q == 4'h7)) else $error("dram select");
    AST_PERIPH_BANK: assert property (bus_ready |->
        periph_select == (bank_q == 4'hF)) else $error("peripheral select");
    AST_HIGH_ABORT: assert property (bus_ready && bank_q inside {[8:14]}
        |-> bus_abort) else $error("unused bank not aborted");
    AST_REMAP_SET: assert property (remap_cmd |=> remapped)
        else $error("remap not taken");
    AST_REMAP_HOLD: assert property (remapped |=> remapped)
        else $error("remap state lost");
    AST_SPLIT_FOLLOW: assert property (coupled_map_config != 2'h3 |=>
        split_active == $past(coupled_map_config)) else $error("split");
    AST_SPLIT_KEEP: assert property (coupled_map_config == 2'h3 |=>
        $stable(split_active)) else $error("illegal split taken");
    AST_WAIT_EXTRA: assert property (coupled_sram_select && !coupled_ready
        |=> coupled_sram_select && coupled_ready) else $error("wait state");
    AST_NOWAIT_READY: assert property (coupled_valid
        && !coupled_mem_wait_state && !$past(coupled_mem_wait_state)
        |=> coupled_ready) else $error("coupled answer late");
    COV_REMAP: cover property (remap_cmd ##1 remapped);
    COV_WAIT: cover property (coupled_sram_select && !coupled_ready);
    COV_ABORT: cover property (bus_ready && bus_abort);
endmodule : memory_map_decoder_remap_checker

// ===== bus_master_model.sv
// Processor and bus master model driving the decoder request ports
module bus_master_model (
    input  wire logic   clk_sys,
    output logic        bus_valid,
    output logic [31:0] bus_addr,
    output logic        bus_master_cpu,
    output logic        coupled_valid,
    output logic        coupled_is_instr,
    output logic [15:0] coupled_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------
    // Requests change just after an edge, held one cycle
    // ----------------------------------------------
    initial begin
        {bus_valid, bus_addr, bus_master_cpu} = 34'h0;
        {coupled_valid, coupled_is_instr, coupled_addr} = 18'h0;
    end
    // Calls in a row give back to back accesses
    task automatic bus_req(input logic [31:0] a, input logic cpu);
        @(posedge clk_sys);
        bus_valid      <= 1'b1;
        bus_addr       <= a;
        bus_master_cpu <= cpu;
    endtask : bus_req
    // Inverted address so a stale value never looks valid
    task automatic bus_idle();
        @(posedge clk_sys);
        bus_valid <= 1'b0;
        bus_addr  <= ~bus_addr;
    endtask : bus_idle
    task automatic cpl_req(input logic instr, input logic [15:0] a);
        @(posedge clk_sys);
        coupled_valid    <= 1'b1;
        coupled_is_instr <= instr;
        coupled_addr     <= a;
    endtask : cpl_req
    task automatic cpl_idle();
        @(posedge clk_sys);
        coupled_valid <= 1'b0;
        coupled_addr  <= ~coupled_addr;
    endtask : cpl_idle
endmodule : bus_master_model

// ===== tb_memory_map_decoder_remap.sv
// Self-checking bench for the memory map decoder
module tb_memory_map_decoder_remap;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        remap_cmd = 1'b0;
    logic        boot_memory_select = 1'b1;
    logic        coupled_mem_wait_state = 1'b0;
    logic [1:0]  coupled_map_config = 2'h0;
    logic        bus_valid, bus_master_cpu, coupled_valid, coupled_is_instr;
    logic [31:0] bus_addr;
    logic [15:0] coupled_addr, sram_bus_offset;
    logic [5:0]  ext_select_n;
    logic [1:0]  split_active;
    logic        dram_chip_select_n, periph_select, sram_bus_select;
    logic        rom_select, alt_boot_select, bus_abort, bus_ready;
    logic        coupled_sram_select, coupled_abort, coupled_ready, remapped;
    logic        remap_m, strap_m;        // Expected remap and strap
    logic [1:0]  split_m;                 // Expected split in force
    logic [28:0] exp_q[$];                // Expected answers, oldest first
    logic [19:0] edge_o[4] = '{20'h07FFF, 20'h08000, 20'h0FFFF, 20'h10000};
    int          n_fail = 0;
    int          n_tests = 0;
    always #50 clk_sys = ~clk_sys;
    bus_master_model bm (.clk_sys, .bus_valid, .bus_addr, .bus_master_cpu,
        .coupled_valid, .coupled_is_instr, .coupled_addr);
    memory_map_decoder_remap dut (.clk_sys, .resetn, .bus_valid, .bus_addr,
        .bus_master_cpu, .coupled_valid, .coupled_is_instr, .coupled_addr,
        .remap_cmd, .boot_memory_select, .coupled_map_config,
        .coupled_mem_wait_state, .ext_select_n, .dram_chip_select_n,
        .periph_select, .sram_bus_select, .sram_bus_offset, .rom_select,
        .alt_boot_select, .bus_abort, .bus_ready, .coupled_sram_select,
        .coupled_abort, .coupled_ready, .remapped, .split_active);
    // ------------------------------------------------
    // Expected answers from the memory map
    // ------------------------------------------------
    // Size of a coupled part under the expected split
    function automatic logic [19:0] sz(input logic instr);
        if (instr) return (split_m == 2'h2) ? 20'h08000 : 20'h0;
        return (split_m == 2'h1) ? 20'h10000 : sz(1'b1);
    endfunction : sz
    function automatic logic [28:0] exp_bus(input logic [31:0] a,
                                            input logic cpu);
        logic [19:0] o, bs;
        logic [15:0] f;
        logic [2:0]  t;
        o = a[19:0];
        bs = (split_m == 2'h0) ? 20'h10000 : 20'h0;
        f = 16'((a[27:20] == 8'h02) ? o + sz(1'b1) : o);
        t = 3'h6;
        if (a[31:28] == 4'h0) begin
            case (a[27:20])
                8'h00: t = remap_m ? ((cpu && o < bs) ? 3'h3 : 3'h6)
                    : !strap_m ? 3'h5 : (o < 20'h10000) ? 3'h4 : 3'h6;
                8'h01: t = (o < sz(1'b1)) ? 3'h3 : 3'h6;
                8'h02: t = (o < sz(1'b0)) ? 3'h3 : 3'h6;
                8'h03: t = (o < bs) ? 3'h3 : 3'h6;
                8'h04: t = (o < 20'h10000) ? 3'h4 : 3'h6;
                default: t = 3'h6;
            endcase
        end else if (a[31:28] <= 4'h6) t = 3'h0;
        else if (a[31:28] == 4'h7) t = 3'h1;
        else if (a[31:28] == 4'hF) t = 3'h2;
        return {1'b0, (t == 3'h0) ? ~(6'h01 << (a[31:28] - 4'h1)) : 6'h3F,
            t != 3'h1, t == 3'h2, t == 3'h3, (t == 3'h3) ? f : 16'h0,
            t == 3'h4, t == 3'h5, t == 3'h6};
    endfunction : exp_bus
    task automatic chk(input logic [28:0] got, input logic [28:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic [31:0] a, input logic cpu);
        exp_q.push_back(exp_bus(a, cpu));
        bm.bus_req(a, cpu);
    endtask : acc
    // With the wait bit on, requests are spaced two cycles apart
    task automatic cacc(input logic instr, input logic [15:0] a);
        logic hit;
        hit = {4'h0, a} < sz(instr);
        exp_q.push_back({1'b1, 26'h0, hit, !hit});
        bm.cpl_req(instr, a);
        if (coupled_mem_wait_state) bm.cpl_idle();
    endtask : cacc
    // Monitor: every answer takes the oldest expectation
    always @(negedge clk_sys) begin
        if (resetn === 1'b1 && (bus_ready === 1'b1 || coupled_ready === 1'b1))
            chk(bus_ready ? {1'b0, ext_select_n, dram_chip_select_n,
                periph_select, sram_bus_select,
                sram_bus_select ? sram_bus_offset : 16'h0, rom_select,
                alt_boot_select, bus_abort}
                : {1'b1, 26'h0, coupled_sram_select, coupled_abort},
                exp_q.size() ? exp_q.pop_front() : 29'h1FFFFFFF);
    end
    task automatic run(input logic strap);
        int p, s, w, b, r, k;
        resetn <= 1'b0;
        boot_memory_select <= strap;
        coupled_map_config <= 2'h0;
        coupled_mem_wait_state <= 1'b0;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({18'h0, ext_select_n, dram_chip_select_n, bus_abort, remapped,
            split_active}, {18'h0, 6'h3F, 1'b1, 4'h0});
        @(posedge clk_sys);
        resetn <= 1'b1;
        {strap_m, remap_m, split_m} = {strap, 3'h0};
        repeat (3) @(posedge clk_sys);
        boot_memory_select <= ~strap;
        for (p = 0; p < 2; p++) begin
            if (p == 1) begin
                remap_cmd <= 1'b1;
                @(posedge clk_sys);
                remap_cmd <= 1'b0;
                @(negedge clk_sys);
                remap_m = 1'b1;
                chk({28'h0, remapped}, 29'h1);
            end
            for (s = 0; s < 4; s++) begin
                @(posedge clk_sys);
                coupled_map_config <= 2'(s);
                if (s != 3) split_m = 2'(s);
                repeat (2) @(negedge clk_sys);
                chk({27'h0, split_active}, {27'h0, split_m});
                for (b = 1; b < 16; b++)
                    acc({4'(b), 28'($urandom)}, 1'($urandom));
                for (r = 0; r < 6; r++)
                    for (k = 0; k < 6; k++)
                        acc({12'(r), k < 4 ? edge_o[k] : 20'($urandom)},
                            1'(k));
                bm.bus_idle();
                for (w = 0; w < 2; w++) begin
                    repeat (3) @(posedge clk_sys);
                    coupled_mem_wait_state <= 1'(w);
                    repeat (2) @(posedge clk_sys);
                    for (k = 0; k < 6; k++)
                        cacc(1'(k),
                            k < 4 ? edge_o[k][15:0] : 16'($urandom));
                    bm.cpl_idle();
                end
            end
        end
        repeat (4) @(posedge clk_sys);
    endtask : run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(33990));
        run(1'b1);
        run(1'b0);
        for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge clk_sys);
        if (exp_q.size() != 0) n_fail++;
        final_report();
    end
endmodule : tb_memory_map_decoder_remap
bind memory_map_decoder_remap memory_map_decoder_remap_checker chk_i (
    .clk_sys, .resetn, .bus_valid, .bus_addr, .coupled_valid,
    .coupled_mem_wait_state, .coupled_map_config, .remap_cmd, .ext_select_n,
    .dram_chip_select_n, .periph_select, .sram_bus_select, .rom_select,
    .alt_boot_select, .bus_abort, .bus_ready, .coupled_sram_select,
    .coupled_ready, .remapped, .split_active);
